// ---- core/lcd_pwr_pkg.sv ----
// Shared constants for the LCD reset and operating-mode sequencer pair.
// Assumes a single 125 MHz clock shared by both ends.
package lcd_pwr_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int POR_WAIT_US = 5000;
  localparam int POR_WAIT_CYCLES = POR_WAIT_US * CLK_MHZ;
  localparam int HOST_WAIT_US = 10000;
  localparam int HOST_WAIT_CYCLES = HOST_WAIT_US * CLK_MHZ;

  // ----------------------------------------
  // Operating mode codes
  // ----------------------------------------
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  // ----------------------------------------
  // Cycle selects and command bytes
  // ----------------------------------------
  localparam logic SEL_COMMAND = 1'b0;
  localparam logic SEL_DATA = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] CMD_DISPLAY_ON = 8'hAF;
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
  localparam logic [7:0] CMD_SYS_RESET = 8'hE2;

  // ----------------------------------------
  // Host-side register map (AHB-Lite, byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam int CTRL_RST_PIN_BIT = 0;
  localparam int CTRL_EXT_LCD_DRIVE_VOLTAGE_BIT = 1;
  localparam int CMD_DATA_SEL_BIT = 8;
  localparam int CMD_DIR_BIT = 9;

endpackage : lcd_pwr_pkg

// ---- core/lcd_host_if.sv ----
// Link between host controller and LCD device: reset pin plus
// one-cycle host interface strobe with select, direction and byte.
`timescale 1ns/1ps
interface lcd_host_if;
  logic rst_pin_n;
  logic cyc_valid;
  logic cyc_data_sel;
  logic cyc_dir;
  logic [7:0] cyc_wdata;
  logic [7:0] cyc_rdata;
  logic ext_lcd_drive_voltage;

  modport device (
    input rst_pin_n, cyc_valid, cyc_data_sel, cyc_dir, cyc_wdata, ext_lcd_drive_voltage,
    output cyc_rdata
  );
  modport host (
    output rst_pin_n, cyc_valid, cyc_data_sel, cyc_dir, cyc_wdata, ext_lcd_drive_voltage,
    input cyc_rdata
  );
endinterface : lcd_host_if

// ---- core/lcd_reset_power_mode_control.sv ----
// Device end: power-on delay, system reset, operating mode and
// gating of clock, drivers, pump and drain.
// Assumes the host interface strobe is synchronous to I_CLK.
`timescale 1ns/1ps

// Overview of operation
// R1 - Power-on waits about 5 ms, then resets
// R2 - Reset command or pin low also resets
// R3 - Reset sets mode Reset, controls default
// R4 - Mode codes: Reset 00, Sleep 10, Normal 11
// R5 - Host always accepted; blocks on only Normal
// R6 - Display enable write selects Sleep or Normal
// R7 - Only reset paths enter mode 00
// R8 - Sleep keeps charge; drain only in Reset
// R9 - Drivers idle until voltages report ready
// R10 - Host waits 5 to 10 ms first
// R11 - Commands accepted back to back, no waits
// R12 - External LCD voltage never drained
// R13 - Host resets, waits RC times before power-off
// R14 - Cycle carries data select and direction
// R15 - Display memory retained through Sleep
// R16 - Host uses Sleep only briefly
// R17 - Reset pin synchronised first; reset command used unsynchronised
// R18 - Commands AF, AE, E2 as command writes
module lcd_reset_power_mode_control
  import lcd_pwr_pkg::*;
#(
  parameter int POR_CYCLES = POR_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Host link
  lcd_host_if.device LINK,
  // Analog readiness
  input wire logic I_LCD_VOLTAGE_READY,
  input wire logic I_BIAS_VOLTAGE_READY,
  // Mode and gating outputs
  output logic [1:0] O_OPERATING_MODE_CODE,
  output logic O_SYS_RESET,
  output logic O_CLK_EN,
  output logic O_PUMP_EN,
  output logic O_DRAIN_EN,
  output logic O_ROW_DRIVER_ACTIVE,
  output logic O_COLUMN_DRIVER_ACTIVE,
  // Display memory write port
  output logic O_MEM_WE,
  output logic [7:0] O_MEM_WDATA
);
  import lcd_pwr_pkg::*;

  initial begin
    if (POR_CYCLES < 1) begin
      $error("POR_CYCLES must be at least one");
    end
  end

  // ----------------------------------------
  // Link cycle decode
  // ----------------------------------------
  // One cycle of the wanted kind, from the host's select and direction
  function automatic logic link_cycle(
    input logic valid,
    input logic data_sel,
    input logic dir,
    input logic want_sel,
    input logic want_dir
  );
    return valid && data_sel == want_sel && dir == want_dir;
  endfunction : link_cycle

  // A command write carrying the given byte
  function automatic logic cmd_is(input logic wr, input logic [7:0] byte_in,
    input logic [7:0] code);
    return wr && byte_in == code;
  endfunction : cmd_is

  // ----------------------------------------
  // Power-on wait
  // ----------------------------------------
  logic [31:0] por_count;
  logic por_done;
  logic por_pulse;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      por_count <= 32'h0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      if (por_count == 32'(POR_CYCLES - 1)) begin
        por_done <= 1'b1; // R1
      end
      por_count <= por_count + 32'h1;
    end
  end

  assign por_pulse = !por_done && (por_count == 32'(POR_CYCLES - 1)); // R1

  // ----------------------------------------
  // Reset pin synchroniser and command decode
  // ----------------------------------------
  logic pin_meta;
  logic pin_sync;
  logic cmd_wr;
  logic data_wr;
  logic cmd_reset;
  logic reset_req;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= LINK.rst_pin_n; // R17
      pin_sync <= pin_meta;
    end
  end

  // Command writes are accepted in every mode, in every cycle with O_SYS_RESET low
  assign cmd_wr = link_cycle(LINK.cyc_valid, LINK.cyc_data_sel, LINK.cyc_dir,
    SEL_COMMAND, DIR_WRITE); // R14 R5 R11
  assign data_wr = link_cycle(LINK.cyc_valid, LINK.cyc_data_sel, LINK.cyc_dir,
    SEL_DATA, DIR_WRITE); // R14 R11
  assign cmd_reset = cmd_is(cmd_wr, LINK.cyc_wdata, CMD_SYS_RESET); // R18

  // Registered so the reset asserts before the mode clears
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_SYS_RESET <= 1'b0;
    end else begin
      O_SYS_RESET <= por_pulse || !pin_sync || cmd_reset; // R2 R17
    end
  end
  assign reset_req = O_SYS_RESET;

  // ----------------------------------------
  // Operating mode
  // ----------------------------------------
  logic display_enable_bit;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || reset_req) begin
      display_enable_bit <= 1'b0; // R3
      O_OPERATING_MODE_CODE <= MODE_RESET; // R3 R7
    end else if (cmd_is(cmd_wr, LINK.cyc_wdata, CMD_DISPLAY_ON)) begin
      display_enable_bit <= 1'b1;
      O_OPERATING_MODE_CODE <= MODE_NORMAL; // R6 R4 R18
    end else if (cmd_is(cmd_wr, LINK.cyc_wdata, CMD_DISPLAY_OFF)) begin
      display_enable_bit <= 1'b0;
      O_OPERATING_MODE_CODE <= MODE_SLEEP; // R6 R4 R18
    end
  end

  // ----------------------------------------
  // Block gating
  // ----------------------------------------
  logic normal;
  assign normal = O_OPERATING_MODE_CODE == MODE_NORMAL && display_enable_bit;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_CLK_EN <= 1'b0;
      O_PUMP_EN <= 1'b0;
    end else begin
      O_CLK_EN <= normal; // R5
      // External LCD supply means the pump stays off
      O_PUMP_EN <= normal && !LINK.ext_lcd_drive_voltage; // R5 R12
    end
  end

  // Sleep keeps the caps charged; external supply is never drained
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_DRAIN_EN <= 1'b0;
    end else begin
      O_DRAIN_EN <= O_OPERATING_MODE_CODE == MODE_RESET && !LINK.ext_lcd_drive_voltage; // R8 R12
    end
  end

  // Drivers stay idle until both voltages report ready
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_ROW_DRIVER_ACTIVE <= 1'b0;
      O_COLUMN_DRIVER_ACTIVE <= 1'b0;
    end else begin
      O_ROW_DRIVER_ACTIVE <= normal && I_LCD_VOLTAGE_READY && I_BIAS_VOLTAGE_READY; // R9
      O_COLUMN_DRIVER_ACTIVE <= normal && I_LCD_VOLTAGE_READY && I_BIAS_VOLTAGE_READY; // R9
    end
  end

  // ----------------------------------------
  // Display memory writes and read back
  // ----------------------------------------
  // Memory itself lives elsewhere and is untouched by mode changes
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_MEM_WE <= 1'b0;
      O_MEM_WDATA <= 8'h00;
    end else begin
      O_MEM_WE <= data_wr; // R15 R11
      if (data_wr) begin
        O_MEM_WDATA <= LINK.cyc_wdata;
      end
    end
  end

  // Status mirror registered every cycle, so a read sees the mode one cycle late
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      LINK.cyc_rdata <= 8'h00;
    end else begin
      LINK.cyc_rdata <= {5'h00, display_enable_bit, O_OPERATING_MODE_CODE}; // R14 R4
    end
  end

endmodule : lcd_reset_power_mode_control

// ---- core/lcd_host_ctrl.sv ----
// Host end: AHB-Lite slave registers that drive the reset pin and
// issue one host interface cycle per write to the command register.
// Assumes hsel/htrans single word transfers from one master.
`timescale 1ns/1ps
module lcd_host_ctrl
  import lcd_pwr_pkg::*;
#(
  parameter int WAIT_CYCLES = HOST_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [7:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Link to device
  lcd_host_if.host LINK
);
  import lcd_pwr_pkg::*;

  initial begin
    if (WAIT_CYCLES < 1) begin
      $error("WAIT_CYCLES must be at least one");
    end
  end

  // ----------------------------------------
  // Power-up wait before first command
  // ----------------------------------------
  logic [31:0] wait_count;
  logic ready;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      wait_count <= 32'h0;
    end else if (!ready) begin
      wait_count <= wait_count + 32'h1; // R10
    end
  end
  assign ready = wait_count >= 32'(WAIT_CYCLES);

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic wr_pend;
  logic [7:0] addr;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      wr_pend <= 1'b0;
      addr <= 8'h00;
    end else if (I_HREADY && O_HREADYOUT) begin
      wr_pend <= I_HSEL && I_HTRANS[1] && I_HWRITE;
      addr <= I_HADDR;
    end
  end

  // Command writes stall until the power-up wait is over
  assign O_HREADYOUT = !(wr_pend && addr == REG_CMD && !ready); // R10
  assign O_HRESP = 1'b0;

  // ----------------------------------------
  // Registers and link drive
  // ----------------------------------------
  logic ctrl_rst;
  logic ctrl_ext;
  logic [7:0] rdata;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ctrl_rst <= 1'b0;
      ctrl_ext <= 1'b0;
      LINK.cyc_valid <= 1'b0;
      LINK.cyc_data_sel <= 1'b0;
      LINK.cyc_dir <= 1'b0;
      LINK.cyc_wdata <= 8'h00;
    end else begin
      LINK.cyc_valid <= 1'b0;
      if (wr_pend && O_HREADYOUT && addr == REG_CTRL) begin
        ctrl_rst <= I_HWDATA[CTRL_RST_PIN_BIT];
        ctrl_ext <= I_HWDATA[CTRL_EXT_LCD_DRIVE_VOLTAGE_BIT];
      end
      if (wr_pend && O_HREADYOUT && addr == REG_CMD) begin
        LINK.cyc_valid <= 1'b1;
        LINK.cyc_data_sel <= I_HWDATA[CMD_DATA_SEL_BIT]; // R14
        LINK.cyc_dir <= I_HWDATA[CMD_DIR_BIT]; // R14
        LINK.cyc_wdata <= I_HWDATA[7:0];
      end
    end
  end

  // Power-down drain wait (R13) and Sleep policy (R16) are software's
  assign LINK.rst_pin_n = !ctrl_rst;
  assign LINK.ext_lcd_drive_voltage = ctrl_ext;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rdata <= 8'h00;
    end else begin
      rdata <= LINK.cyc_rdata;
    end
  end

  always_comb begin
    unique case (addr)
      REG_CTRL: O_HRDATA = {30'h0, ctrl_ext, ctrl_rst};
      REG_STATUS: O_HRDATA = {31'h0, ready};
      REG_RDATA: O_HRDATA = {24'h0, rdata};
      default: O_HRDATA = 32'h0;
    endcase
  end

endmodule : lcd_host_ctrl

// ---- tb/lcd_pwr_monitor.sv ----
// Checker on the link between host controller and LCD device.
// Assumes one clock; cyc_rdata carries {5'b0, display enable, mode}.
`timescale 1ns/1ps
module lcd_pwr_monitor
  import lcd_pwr_pkg::*;
#(
  parameter int WAIT_CYCLES = 20
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Link
  input wire logic rst_pin_n,
  input wire logic cyc_valid,
  input wire logic cyc_data_sel,
  input wire logic cyc_dir,
  input wire logic [7:0] cyc_wdata,
  input wire logic [7:0] cyc_rdata
);
  int age;
  int since;
  logic cw;
  assign cw = cyc_valid && cyc_data_sel == SEL_COMMAND && cyc_dir == DIR_WRITE;
  // Cycles since bus reset, reset pin low or reset command (not power-on), saturating at 15
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || !rst_pin_n || (cw && cyc_wdata == CMD_SYS_RESET)) age <= 0;
    else if (age < 15) age <= age + 1;
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) since <= 0;
    else if (since < WAIT_CYCLES) since <= since + 1;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  status_zero_a: assert property (cyc_rdata[7:3] == 5'h00)
    else $error("status upper bits set");
  mode_code_a: assert property (cyc_rdata[1:0] != 2'h1)
    else $error("illegal mode code");
  display_on_a: assert property (cw && cyc_wdata == CMD_DISPLAY_ON && rst_pin_n
    |-> ##[1:4] cyc_rdata[2:0] == 3'h7) else $error("enable did not reach Normal");
  display_off_a: assert property (cw && cyc_wdata == CMD_DISPLAY_OFF && rst_pin_n
    |-> ##[1:4] cyc_rdata[2:0] == 3'h2) else $error("disable did not reach Sleep");
  cmd_reset_a: assert property (cw && cyc_wdata == CMD_SYS_RESET
    |-> ##[1:4] cyc_rdata[2:0] == 3'h0) else $error("reset command ignored");
  pin_reset_a: assert property (!rst_pin_n [*8] |-> cyc_rdata[2:0] == 3'h0)
    else $error("reset pin ignored");
  reset_only_a: assert property (cyc_rdata[1:0] == MODE_RESET
    && $past(cyc_rdata[1:0]) != MODE_RESET |-> age < 8) else $error("stray entry to Reset");
  release_idle_a: assert property ($rose(I_RST_N) |-> rst_pin_n && !cyc_valid)
    else $error("link busy after reset");
  host_wait_a: assert property (cyc_valid |-> since >= WAIT_CYCLES)
    else $error("command before host wait");
  cover property (cw && cyc_wdata == CMD_DISPLAY_ON);
  cover property (cw && cyc_wdata == CMD_SYS_RESET);
  cover property (cyc_valid && cyc_data_sel == SEL_DATA);
  cover property (!rst_pin_n [*8]);
endmodule : lcd_pwr_monitor

// ---- tb/tb_lcd_reset_power_mode_control.sv ----
// Testbench: host controller and LCD device joined by their link.
// Assumes short POR and host wait parameters for a brief run.
`timescale 1ns/1ps
module tb_lcd_reset_power_mode_control;
  import lcd_pwr_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, lrdy = 0, brdy = 0, rd = 0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata;
  wire hrdyo, hresp, sysr, ce, pe, de, ra, ca, we;
  wire [1:0] mode;
  wire [7:0] wdat;
  int n_errors = 0, compares = 0, seed = 32'h0778;
  logic [31:0] mq[$], rq[$];
  lcd_host_if lcd_host_if_i ();
  lcd_host_ctrl #(.WAIT_CYCLES(20)) lcd_host_ctrl_i (.I_CLK(clk), .I_RST_N(rst_n),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hrdyo), .O_HRDATA(hrdata), .O_HREADYOUT(hrdyo),
    .O_HRESP(hresp), .LINK(lcd_host_if_i));
  lcd_reset_power_mode_control #(.POR_CYCLES(10)) lcd_reset_power_mode_control_i (
    .I_CLK(clk), .I_RST_N(rst_n), .LINK(lcd_host_if_i), .I_LCD_VOLTAGE_READY(lrdy),
    .I_BIAS_VOLTAGE_READY(brdy), .O_OPERATING_MODE_CODE(mode), .O_SYS_RESET(sysr),
    .O_CLK_EN(ce), .O_PUMP_EN(pe), .O_DRAIN_EN(de), .O_ROW_DRIVER_ACTIVE(ra),
    .O_COLUMN_DRIVER_ACTIVE(ca), .O_MEM_WE(we), .O_MEM_WDATA(wdat));
  lcd_pwr_monitor #(.WAIT_CYCLES(20)) lcd_pwr_monitor_i (.I_CLK(clk), .I_RST_N(rst_n),
    .rst_pin_n(lcd_host_if_i.rst_pin_n), .cyc_valid(lcd_host_if_i.cyc_valid),
    .cyc_data_sel(lcd_host_if_i.cyc_data_sel), .cyc_dir(lcd_host_if_i.cyc_dir),
    .cyc_wdata(lcd_host_if_i.cyc_wdata), .cyc_rdata(lcd_host_if_i.cyc_rdata));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // Reads carry their expected word in d
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdyo !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    if (w) hwdata <= d;
    else rq.push_back(d);
    rd <= !w;
    do @(posedge clk); while (hrdyo !== 1'b1);
    rd <= 1'b0;
  endtask : ahb
  task automatic cmd(input logic [9:0] c, input int gap);
    if (c[9:8] == 2'h1) mq.push_back({24'h0, c[7:0]});
    ahb(1'b1, REG_CMD, {22'h0, c});
    repeat (gap) @(posedge clk);
  endtask : cmd
  task automatic chk(input logic [1:0] m, input logic x);
    logic n;
    logic r;
    n = (m == MODE_NORMAL);
    r = n && lrdy && brdy;
    cmp({mode, ce, pe, de, ra, ca}, {m, n, n && !x, m == MODE_RESET && !x, r, r});
  endtask : chk
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // Result watchers
  // ----------------------------------------
  always @(posedge clk) begin
    if (rd && hrdyo) cmp(hrdata, rq.pop_front());
    if (we) cmp({24'h0, wdat}, mq.size() ? mq.pop_front() : 32'hFFFF_FFFF);
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    chk(MODE_RESET, 1'b0);
    cmd(CMD_DISPLAY_ON, 6);
    chk(MODE_NORMAL, 1'b0);
    lrdy <= 1'b1;
    brdy <= 1'b1;
    repeat (4) @(posedge clk);
    chk(MODE_NORMAL, 1'b0);
    $display("test power-up done");
    // Back to back data, Sleep entered midway
    for (int i = 0; i < 6; i++) begin
      if (i == 3) cmd(CMD_DISPLAY_OFF, 0);
      cmd({2'h1, 8'($random(seed))}, 0);
    end
    repeat (6) @(posedge clk);
    chk(MODE_SLEEP, 1'b0);
    cmd(CMD_DISPLAY_ON, 6);
    cmd({2'h2, 8'h00}, 6);
    ahb(1'b0, REG_RDATA, 32'h7);
    ahb(1'b0, 8'h10, 32'h0);
    $display("test traffic done");
    for (int x = 0; x < 2; x++) begin
      ahb(1'b1, REG_CTRL, 32'(x << 1));
      cmd(CMD_DISPLAY_ON, 6);
      chk(MODE_NORMAL, x[0]);
      cmd(CMD_SYS_RESET, 6);
      chk(MODE_RESET, x[0]);
    end
    cmd(CMD_DISPLAY_ON, 6);
    ahb(1'b1, REG_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    chk(MODE_RESET, 1'b0);
    cmp({31'h0, sysr}, 32'h1);
    ahb(1'b1, REG_CTRL, 32'h0);
    repeat (6) @(posedge clk);
    chk(MODE_RESET, 1'b0);
    $display("test reset paths done");
    summarize();
  end
endmodule : tb_lcd_reset_power_mode_control
